//--- rtl/mce_pkg.sv
// Purpose: shared constants and types of the meter calibration engine
// Assumes: 24-bit coefficients, channels 0..3 = voltage 1, current 1, voltage 2, current 2
// Notes: register indices are word addresses on the plain register port
package mce_pkg;
  localparam int DW = 24; // coefficient and sample width
  localparam int NCH = 4; // channel count
  localparam int NCUR = 2; // current channels
  localparam int AW = 5; // register address width
  localparam int SW = 48; // sum and divider width
  localparam int DIV_CW = 6; // divider step counter width
  localparam logic [DIV_CW-1:0] DIV_LAST = 6'h2f; // last of SW steps
  localparam int GAIN_POINT = 22; // fraction bits of a gain
  localparam int GAIN_CAL_SHIFT = 23; // Q1.23 over Q0.24 into Q2.22
  // register map
  localparam logic [AW-1:0] ADDR_CMD = 5'h00;
  localparam logic [AW-1:0] ADDR_STATUS = 5'h01;
  localparam logic [AW-1:0] ADDR_COUNT = 5'h02;
  localparam logic [AW-1:0] ADDR_SETTLE = 5'h03;
  localparam logic [AW-1:0] ADDR_SCALE = 5'h04;
  localparam logic [AW-1:0] ADDR_DCOFF = 5'h08; // plus channel
  localparam logic [AW-1:0] ADDR_GAIN = 5'h0c; // plus channel
  localparam logic [AW-1:0] ADDR_ACOFF = 5'h10; // plus current index
  // command word fields
  localparam int CMD_TYPE_LSB = 0;
  localparam int CMD_CH_LSB = 2;
  // status word fields
  localparam int CAL_DONE_BIT = 23;
  localparam int VOLTAGE_CH1_OVER_RANGE = 0;
  localparam int CURRENT_CH1_OVER_RANGE = 1;
  localparam int VOLTAGE_CH2_OVER_RANGE = 2;
  localparam int CURRENT_CH2_OVER_RANGE = 3;
  // reset values and fixed numbers
  localparam logic [DW-1:0] GAIN_ONE = 24'h400000;
  localparam logic [DW-1:0] SCALE_RST = 24'h4ccccc;
  localparam logic [DW-1:0] VOLT_TARGET = 24'h4ccccc;
  localparam logic [DW-1:0] ZERO_RST = 24'h000000;
  localparam logic [DW-1:0] COUNT_RST = 24'h000010;
  localparam logic [DW-1:0] SETTLE_RST = 24'h000010;
  localparam logic [DW-1:0] ALL_ONES = 24'hffffff;
  localparam logic [DW-1:0] SAT_MAX = 24'h7fffff;
  localparam logic [DW-1:0] SAT_MIN = 24'h800000;
  typedef enum logic [1:0] {
    CAL_NONE = 2'h0, CAL_DC = 2'h1, CAL_AC = 2'h2, CAL_GAIN = 2'h3
  } mce_cal_type;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_SETTLE = 6'h02, ST_AVG = 6'h04,
    ST_ADIV = 6'h08, ST_GDIV = 6'h10, ST_WRITE = 6'h20
  } mce_state_type;
  // odd channel numbers are current channels
  function automatic logic is_current(input logic [1:0] ch);
    return ch[0];
  endfunction : is_current
endpackage : mce_pkg

//--- rtl/mce_if.sv
// Purpose: carrier between the engine and its divider and correction units
// Assumes: one clock, driven by the modules on each side
// Notes: div group is start/done; cor group is tick/valid
`timescale 1ns/1ps
interface mce_if;
  import mce_pkg::*;
  logic div_start; // one-cycle start
  logic [SW-1:0] div_num; // dividend
  logic [SW-1:0] div_den; // divisor
  logic div_done; // one-cycle done
  logic [SW-1:0] div_quo; // quotient
  logic cor_tick; // new raw samples
  logic [NCH-1:0][DW-1:0] cor_raw; // raw samples
  logic [NCH-1:0][DW-1:0] cor_off; // dc offsets
  logic [NCH-1:0][DW-1:0] cor_gain; // gains
  logic cor_valid; // corrected samples fresh
  logic [NCH-1:0][DW-1:0] cor_out; // corrected samples
  logic [NCH-1:0] cor_ovf; // saturation per channel
  modport div_user(output div_start, div_num, div_den, input div_done, div_quo);
  modport div_unit(input div_start, div_num, div_den, output div_done, div_quo);
  modport cor_user(output cor_tick, cor_raw, cor_off, cor_gain,
                   input cor_valid, cor_out, cor_ovf);
  modport cor_unit(input cor_tick, cor_raw, cor_off, cor_gain,
                   output cor_valid, cor_out, cor_ovf);
endinterface : mce_if

//--- rtl/mce_divider.sv
// Purpose: unsigned restoring divider, one quotient bit per clock
// Assumes: operands held stable from start to done
// Notes: a zero divisor yields an all-ones quotient
`timescale 1ns/1ps
module mce_divider
  import mce_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst_n, // async reset
  mce_if.div_unit dv // divide request and answer
);
  logic busy;
  logic [DIV_CW-1:0] step;
  logic [SW-1:0] rem;
  logic [SW:0] rem_sh;
  logic take;
  // one trial subtraction per step
  assign rem_sh = {rem, dv.div_quo[SW-1]};
  assign take = rem_sh >= {1'b0, dv.div_den};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      step <= '0;
      rem <= '0;
      dv.div_quo <= '0;
      dv.div_done <= 1'b0;
    end else begin
      dv.div_done <= 1'b0;
      if (dv.div_start) begin
        busy <= 1'b1;
        step <= '0;
        rem <= '0;
        dv.div_quo <= dv.div_num;
      end else if (busy) begin
        rem <= take ? SW'(rem_sh - {1'b0, dv.div_den}) : rem_sh[SW-1:0];
        dv.div_quo <= {dv.div_quo[SW-2:0], take};
        step <= step + 1'b1;
        if (step == DIV_LAST) begin
          busy <= 1'b0;
          dv.div_done <= 1'b1;
        end
      end
    end
  end
endmodule : mce_divider

//--- rtl/mce_corrector.sv
// Purpose: front-end correction, sample plus dc offset times gain
// Assumes: gain is unsigned Q2.22, samples and offsets signed Q1.23
// Notes: results saturate and raise the channel's overflow flag
`timescale 1ns/1ps
module mce_corrector
  import mce_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst_n, // async reset
  mce_if.cor_unit cr // samples in, corrected samples out
);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) cr.cor_valid <= 1'b0;
    else cr.cor_valid <= cr.cor_tick;
  end
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic signed [DW:0] sum;
    logic signed [2*DW+1:0] prod;
    logic signed [2*DW+1:0] shr;
    logic fits;
    // offset first, then gain, so every later result sees both
    assign sum = $signed({cr.cor_raw[c][DW-1], cr.cor_raw[c]})
               + $signed({cr.cor_off[c][DW-1], cr.cor_off[c]});
    assign prod = sum * $signed({1'b0, cr.cor_gain[c]});
    assign shr = prod >>> GAIN_POINT;
    assign fits = (&shr[2*DW+1:DW-1]) | ~(|shr[2*DW+1:DW-1]);
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        cr.cor_out[c] <= ZERO_RST;
        cr.cor_ovf[c] <= 1'b0;
      end else if (cr.cor_tick) begin
        cr.cor_out[c] <= fits ? shr[DW-1:0] : (shr[2*DW+1] ? SAT_MIN : SAT_MAX);
        cr.cor_ovf[c] <= !fits;
      end
    end
  end
endmodule : mce_corrector

//--- rtl/mce_engine.sv
// Purpose: calibration engine of a four-channel metering front end
// Assumes: owr_tick marks one output-word-rate sample; rms inputs come from
//   the downstream datapath fed by corrected_sample
// Notes: commands arrive as writes to the command register
// What this block does
// RL1: averages the number of samples held in the averaging count register
// RL2: calibration runs settle samples plus averaging samples before writing
// RL3: finishing any calibration sets the completion flag in status
// RL4: overflow during calibration may set matching status overflow bits
// RL5: dc calibration stores negated average dc level in channel offset
// RL6: stored dc offset is added to later instantaneous samples
// RL7: dc offset and gain act at front of path, seen downstream
// RL8: ac offset affects only the rms results, nothing else
// RL9: ac calibration stores square of residual current rms
// RL10: ac offset subtracted inside the current channel rms computation
// RL11: ac offset saturates at all ones full scale
// RL12: voltage gain calibration writes 0.6 divided by voltage rms
// RL13: current gain calibration writes scale divided by current rms
// RL14: gain cannot reach four; such a quotient is an invalid result
// RL15: overflow in calibration or normal use sets channel out-of-range bits
// RL16: calibration scale register resets to 0.6
// RL17: host sets gains to one, settle time, reference before gain calibration
// RL18: host clears ac offset and keeps high-pass filter on before ac calibration
// RL19: host sets gain one, dc offset zero, zero input before dc calibration
// RL20: host may skip dc calibration with high-pass filter, keeping offset zero
// RL21: host redoes ac offset after a later gain calibration
// RL22: each channel owns separate offset and gain registers
// RL23: host commands calibration only while device is active
// RL24: gains are unsigned Q2.22 below four, reset to one
// RL25: ac offsets are unsigned fractions, reset to zero
// RL26: target coefficient written once, with completion flag, after averaging
// RL27: no new calibration starts while one runs
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
module mce_engine
  import mce_pkg::*;
(
  input wire logic ref_clk, // 40 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic [mce_pkg::AW-1:0] addr, // register index
  input wire logic [mce_pkg::DW-1:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [mce_pkg::DW-1:0] rd_data, // read data, cycle after rd_en
  input wire logic owr_tick, // one output-word-rate sample
  input wire logic [mce_pkg::NCH-1:0][mce_pkg::DW-1:0] raw_sample, // raw samples
  input wire logic [mce_pkg::NCUR-1:0][mce_pkg::DW-1:0] mean_sq_in, // current mean squares
  input wire logic [mce_pkg::NCUR-1:0][mce_pkg::DW-1:0] voltage_rms_result, // voltage rms
  input wire logic [mce_pkg::NCUR-1:0][mce_pkg::DW-1:0] current_rms_result, // current rms
  output logic [mce_pkg::NCH-1:0][mce_pkg::DW-1:0] corrected_sample, // front-end output
  output logic [mce_pkg::NCUR-1:0][mce_pkg::DW-1:0] corrected_mean_sq, // ac-corrected
  output logic cal_busy, // calibration running
  output logic [mce_pkg::DW-1:0] status_word_first // status word
);
  import mce_pkg::*;

  mce_if bus_if ();
  mce_state_type state;
  mce_cal_type cal_kind;
  logic [1:0] cal_ch;
  logic [DW-1:0] averaging_sample_count;
  logic [DW-1:0] settle_time;
  logic [DW-1:0] cal_scale;
  logic [NCH-1:0][DW-1:0] dc_offset_coeff;
  logic [NCH-1:0][DW-1:0] gain_coeff;
  logic [NCUR-1:0][DW-1:0] current_ac_offset_coeff;
  logic cal_done_flag;
  logic [NCH-1:0] over_range;
  logic [DW-1:0] cnt;
  logic [SW-1:0] acc;
  logic [SW-1:0] avg_mag;
  logic acc_neg;
  logic [SW-1:0] acc_fin;
  logic [SW-1:0] acc_abs;
  logic sample_ev;
  logic [DW-1:0] pick;
  logic [SW-1:0] pick_ext;
  logic [DW-1:0] n_eff;
  logic start;
  logic [DW-1:0] next_coeff;
  logic next_ovf;
  logic [2*DW-1:0] square;
  logic [DW-1:0] gain_num;

  // channel within a per-channel register block
  function automatic logic [1:0] reg_ch(input logic [AW-1:0] a);
    return a[1:0];
  endfunction : reg_ch

  // units
  mce_divider u_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .dv(bus_if.div_unit)
  );
  mce_corrector u_cor (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cr(bus_if.cor_unit)
  );
  assign bus_if.cor_tick = owr_tick;
  assign bus_if.cor_raw = raw_sample;
  assign bus_if.cor_off = dc_offset_coeff; // [RL6] [RL7]
  assign bus_if.cor_gain = gain_coeff; // [RL7]
  assign corrected_sample = bus_if.cor_out;
  assign sample_ev = bus_if.cor_valid;

  // command accepted only when idle; busy commands are dropped
  assign start = wr_en && (addr == ADDR_CMD) && (state == ST_IDLE) // [RL27]
              && (wr_data[CMD_TYPE_LSB +: 2] != CAL_NONE);
  // a zero count still averages one sample
  assign n_eff = (averaging_sample_count == ZERO_RST) ? DW'(1) : averaging_sample_count;

  // sample taken per calibration kind
  always_comb begin
    if (cal_kind == CAL_DC) pick = bus_if.cor_out[cal_ch];
    else if (is_current(cal_ch)) pick = current_rms_result[cal_ch[1]];
    else pick = voltage_rms_result[cal_ch[1]];
    pick_ext = (cal_kind == CAL_DC) ? SW'($signed(pick)) : SW'(pick);
  end

  // engine sequence
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cal_kind <= CAL_NONE;
      cal_ch <= 2'h0;
      cnt <= ZERO_RST;
      acc <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            cal_kind <= mce_cal_type'(wr_data[CMD_TYPE_LSB +: 2]);
            cal_ch <= wr_data[CMD_CH_LSB +: 2];
            cnt <= ZERO_RST;
            acc <= '0;
            state <= (settle_time == ZERO_RST) ? ST_AVG : ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (sample_ev) begin
            cnt <= cnt + 1'b1;
            if (cnt + 1'b1 == settle_time) begin // [RL2]
              cnt <= ZERO_RST;
              state <= ST_AVG;
            end
          end
        end
        ST_AVG: begin
          if (sample_ev) begin
            acc <= acc + pick_ext; // [RL1]
            cnt <= cnt + 1'b1;
            if (cnt + 1'b1 == n_eff) state <= ST_ADIV; // [RL1] [RL2]
          end
        end
        ST_ADIV: begin
          if (bus_if.div_done) state <= (cal_kind == CAL_GAIN) ? ST_GDIV : ST_WRITE;
        end
        ST_GDIV: begin
          if (bus_if.div_done) state <= ST_WRITE;
        end
        ST_WRITE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // divider requests: magnitude of sum over count, then gain quotient
  assign gain_num = is_current(cal_ch) ? cal_scale : VOLT_TARGET; // [RL12] [RL13]
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_if.div_start <= 1'b0;
      bus_if.div_num <= '0;
      bus_if.div_den <= '0;
      acc_neg <= 1'b0;
      avg_mag <= '0;
    end else begin
      bus_if.div_start <= 1'b0;
      if (state == ST_AVG && sample_ev && cnt + 1'b1 == n_eff) begin
        acc_neg <= (cal_kind == CAL_DC) && acc_fin[SW-1]; // sign after the final sample
        bus_if.div_start <= 1'b1;
        bus_if.div_num <= acc_abs; // [RL1]
        bus_if.div_den <= SW'(n_eff);
      end
      if (state == ST_ADIV && bus_if.div_done) begin
        avg_mag <= bus_if.div_quo;
        if (cal_kind == CAL_GAIN) begin
          bus_if.div_start <= 1'b1;
          bus_if.div_num <= SW'({gain_num, {GAIN_CAL_SHIFT{1'b0}}});
          bus_if.div_den <= bus_if.div_quo;
        end
      end
    end
  end

  // dividend is the sum magnitude with the final sample already in
  assign acc_fin = acc + pick_ext;
  assign acc_abs = ((cal_kind == CAL_DC) && acc_fin[SW-1]) ? SW'(-acc_fin) : acc_fin;

  // coefficient value produced by the finished calibration
  assign square = avg_mag[DW-1:0] * avg_mag[DW-1:0];
  always_comb begin
    next_coeff = ZERO_RST;
    next_ovf = 1'b0;
    case (cal_kind)
      CAL_DC: begin
        if (!acc_neg && avg_mag > SW'(SAT_MIN)) begin
          next_coeff = SAT_MIN;
          next_ovf = 1'b1;
        end else if (acc_neg && avg_mag > SW'(SAT_MAX)) begin
          next_coeff = SAT_MAX; // negating full-scale negative overflows
          next_ovf = 1'b1;
        end else begin
          next_coeff = acc_neg ? avg_mag[DW-1:0] : DW'(-avg_mag[DW-1:0]); // [RL5]
        end
      end
      CAL_AC: begin
        if (|avg_mag[SW-1:DW]) next_coeff = ALL_ONES; // [RL11]
        else next_coeff = square[2*DW-1:DW]; // [RL9]
      end
      CAL_GAIN: begin
        if (|bus_if.div_quo[SW-1:DW]) begin
          next_coeff = ALL_ONES; // [RL14]
          next_ovf = 1'b1;
        end else begin
          next_coeff = bus_if.div_quo[DW-1:0]; // [RL12] [RL13]
        end
      end
      default: next_coeff = ZERO_RST;
    endcase
  end

  // configuration registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      averaging_sample_count <= COUNT_RST;
      settle_time <= SETTLE_RST;
      cal_scale <= SCALE_RST; // [RL16]
    end else if (wr_en) begin
      if (addr == ADDR_COUNT) averaging_sample_count <= wr_data;
      if (addr == ADDR_SETTLE) settle_time <= wr_data;
      if (addr == ADDR_SCALE) cal_scale <= wr_data;
    end
  end

  // per-channel coefficients; the engine writes once, at the end
  for (genvar c = 0; c < NCH; c++) begin : g_coeff
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        dc_offset_coeff[c] <= ZERO_RST;
        gain_coeff[c] <= GAIN_ONE; // [RL24]
      end else if (state == ST_WRITE && cal_ch == 2'(c)) begin
        if (cal_kind == CAL_DC) dc_offset_coeff[c] <= next_coeff; // [RL22] [RL26]
        if (cal_kind == CAL_GAIN) gain_coeff[c] <= next_coeff; // [RL22] [RL26]
      end else if (wr_en && reg_ch(addr) == 2'(c)) begin
        if ((addr & ~5'h03) == ADDR_DCOFF) dc_offset_coeff[c] <= wr_data;
        if ((addr & ~5'h03) == ADDR_GAIN) gain_coeff[c] <= wr_data;
      end
    end
  end

  // ac offsets and the rms-side subtraction for current channels
  for (genvar k = 0; k < NCUR; k++) begin : g_ac
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        current_ac_offset_coeff[k] <= ZERO_RST; // [RL25]
      end else if (state == ST_WRITE && cal_kind == CAL_AC && cal_ch[1] == 1'(k)) begin
        current_ac_offset_coeff[k] <= next_coeff; // [RL9] [RL26]
      end else if (wr_en && addr == ADDR_ACOFF + AW'(k)) begin
        current_ac_offset_coeff[k] <= wr_data;
      end
    end
    // only the rms path sees the ac offset
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) corrected_mean_sq[k] <= ZERO_RST;
      else if (owr_tick) begin
        corrected_mean_sq[k] <= (mean_sq_in[k] > current_ac_offset_coeff[k]) // [RL8]
          ? mean_sq_in[k] - current_ac_offset_coeff[k] : ZERO_RST; // [RL10]
      end
    end
  end

  // status flags: hardware set beats software write-one-to-clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_done_flag <= 1'b0;
      over_range <= '0;
    end else begin
      if (state == ST_WRITE) cal_done_flag <= 1'b1; // [RL3] [RL26]
      else if (wr_en && addr == ADDR_STATUS && wr_data[CAL_DONE_BIT]) cal_done_flag <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        if ((sample_ev && bus_if.cor_ovf[c]) // [RL15]
            || (state == ST_WRITE && next_ovf && cal_ch == 2'(c))) // [RL4]
          over_range[c] <= 1'b1;
        else if (wr_en && addr == ADDR_STATUS && wr_data[c]) over_range[c] <= 1'b0;
      end
    end
  end

  // status outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_busy <= 1'b0;
      status_word_first <= ZERO_RST;
    end else begin
      cal_busy <= (state != ST_IDLE) && (state != ST_WRITE);
      status_word_first <= DW'({cal_done_flag, {(CAL_DONE_BIT-NCH){1'b0}}, over_range});
    end
  end

  // read port: data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rd_data <= ZERO_RST;
    else if (!rd_en) rd_data <= ZERO_RST;
    else begin
      case (addr)
        ADDR_CMD: rd_data <= DW'({state != ST_IDLE, cal_ch, cal_kind});
        ADDR_STATUS: rd_data <= DW'({cal_done_flag, {(CAL_DONE_BIT-NCH){1'b0}}, over_range});
        ADDR_COUNT: rd_data <= averaging_sample_count;
        ADDR_SETTLE: rd_data <= settle_time;
        ADDR_SCALE: rd_data <= cal_scale;
        ADDR_DCOFF, ADDR_DCOFF + 5'h01, ADDR_DCOFF + 5'h02, ADDR_DCOFF + 5'h03:
          rd_data <= dc_offset_coeff[reg_ch(addr)];
        ADDR_GAIN, ADDR_GAIN + 5'h01, ADDR_GAIN + 5'h02, ADDR_GAIN + 5'h03:
          rd_data <= gain_coeff[reg_ch(addr)];
        ADDR_ACOFF, ADDR_ACOFF + 5'h01: rd_data <= current_ac_offset_coeff[addr[0]];
        default: rd_data <= ZERO_RST; // unmapped reads zero
      endcase
    end
  end
endmodule : mce_engine

//--- bench/mce_engine_checker.sv
// Purpose: port-level checks of the calibration engine
// Assumes: one clock, count and settle change only by software
// Notes: bound to every engine instance
`timescale 1ns/1ps
module mce_engine_checker
  import mce_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  input wire logic [mce_pkg::AW-1:0] addr, // index
  input wire logic [mce_pkg::DW-1:0] wr_data, // data
  input wire logic wr_en, // write
  input wire logic owr_tick, // sample
  input wire logic [mce_pkg::NCUR-1:0][mce_pkg::DW-1:0] mean_sq_in, // ms in
  input wire logic [mce_pkg::NCH-1:0][mce_pkg::DW-1:0] corrected_sample, // out
  input wire logic [mce_pkg::NCUR-1:0][mce_pkg::DW-1:0] corrected_mean_sq, // out
  input wire logic cal_busy, // busy
  input wire logic [mce_pkg::DW-1:0] status_word_first // status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [DW-1:0] cnt_m;
  logic [DW-1:0] set_m;
  logic [DW:0] ticks;
  logic clr;
  logic cmd_wr;
  // strobes decoded once for the properties
  assign clr = wr_en && addr == ADDR_STATUS && wr_data[CAL_DONE_BIT];
  assign cmd_wr = wr_en && addr == ADDR_CMD;
  // mirror of count and settle, the engine never writes them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_m <= COUNT_RST;
      set_m <= SETTLE_RST;
    end else if (wr_en && addr == ADDR_COUNT) cnt_m <= wr_data;
    else if (wr_en && addr == ADDR_SETTLE) set_m <= wr_data;
  end
  // ticks while busy; one of slack as the first may precede busy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ticks <= '0;
    else if (!cal_busy) ticks <= '0;
    else if (owr_tick) ticks <= ticks + 1'b1;
  end
  a_min_length: assert property ($fell(cal_busy) |->
    ticks + 1'b1 >= set_m + ((cnt_m == '0) ? 24'h1 : cnt_m)) else $error("too short");
  a_done_at_end: assert property ($fell(cal_busy) |=> status_word_first[CAL_DONE_BIT])
    else $error("no done flag at end");
  a_done_only_end: assert property ($rose(status_word_first[CAL_DONE_BIT]) |->
    $past(cal_busy, 2) && !$past(cal_busy)) else $error("done flag outside end");
  a_done_holds: assert property (status_word_first[CAL_DONE_BIT] && !clr && !$past(clr)
    |=> status_word_first[CAL_DONE_BIT]) else $error("done flag lost");
  a_start_by_cmd: assert property ($rose(cal_busy) |-> $past(cmd_wr, 2))
    else $error("start without command");
  a_sample_timing: assert property (!$past(owr_tick) |-> $stable(corrected_sample))
    else $error("sample moved without tick");
  a_ms_timing: assert property (!$past(owr_tick) |-> $stable(corrected_mean_sq))
    else $error("mean square moved without tick");
  a_ms_bound: assert property ($past(owr_tick) |->
    corrected_mean_sq[0] <= $past(mean_sq_in[0])) else $error("mean square grew");
  c_start: cover property ($rose(cal_busy));
  c_done: cover property ($rose(status_word_first[CAL_DONE_BIT]));
  c_busy_cmd: cover property (cal_busy && cmd_wr);
endmodule : mce_engine_checker

bind mce_engine mce_engine_checker u_chk (.ref_clk, .rst_n, .addr, .wr_data, .wr_en,
  .owr_tick, .mean_sq_in, .corrected_sample, .corrected_mean_sq, .cal_busy,
  .status_word_first);

//--- bench/mce_front_model.sv
// Purpose: sample-rate source of the measurement front end
// Assumes: one tick every gap clocks, low in reset
// Notes: gap exceeds the longest divide so ticks never pile up
`timescale 1ns/1ps
module mce_front_model #(
  parameter int GAP = 200 // clocks per sample
) (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  output logic owr_tick // sample pulse
);
  int cnt;
  // free-running sample divider
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      owr_tick <= 1'b0;
    end else begin
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      owr_tick <= (cnt == GAP - 1);
    end
  end
endmodule : mce_front_model

//--- bench/meter_calibration_engine_test.sv
// Purpose: self-checking bench of the calibration engine
// Assumes: bench plays the host, front model gives the sample rate
// Notes: reads queue their expectation, a monitor compares
`timescale 1ns/1ps
module meter_calibration_engine_test;
  import mce_pkg::*;
  logic ref_clk, rst_n, wr_en, rd_en, owr_tick, cal_busy, was_rd;
  logic [AW-1:0] addr;
  logic [DW-1:0] wr_data, rd_data, status_word_first, r;
  logic [NCH-1:0][DW-1:0] raw_sample, corrected_sample;
  logic [NCUR-1:0][DW-1:0] mean_sq_in, v_rms, i_rms, corrected_mean_sq;
  logic [DW-1:0] exp_q[$];
  int bad_count, samples_checked, seed, k;
  mce_engine DUT (.ref_clk, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .owr_tick,
    .raw_sample, .mean_sq_in, .voltage_rms_result(v_rms), .current_rms_result(i_rms),
    .corrected_sample, .corrected_mean_sq, .cal_busy, .status_word_first);
  mce_front_model u_src (.ref_clk, .rst_n, .owr_tick);
  initial begin
    ref_clk = 0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    rd_en <= 1'b0;
  endtask : rd
  // clear status first so every done flag seen is fresh
  task automatic go(input logic [3:0] c);
    wr(ADDR_STATUS, 24'h80000f);
    wr(ADDR_CMD, {20'h0, c});
  endtask : go
  task automatic fin;
    int i;
    repeat (2) @(negedge ref_clk);
    for (i = 0; i < 20000 && cal_busy !== 1'b0; i++) @(negedge ref_clk);
    chk("cal_busy", '0, {23'h0, cal_busy});
  endtask : fin
  task automatic tick;
    @(posedge owr_tick);
    repeat (2) @(negedge ref_clk);
  endtask : tick
  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk) was_rd <= rd_en;
  always @(negedge ref_clk) begin
    if (was_rd) chk("rd_data", exp_q.pop_front(), rd_data);
  end
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    final_report();
  end
  initial begin
    seed = 32'h933d;
    r = 24'($random(seed)) & 24'h0fffff;
    rst_n = 0;
    wr_en = 0;
    rd_en = 0;
    addr = '0;
    wr_data = '0;
    raw_sample = '0;
    mean_sq_in = '0;
    v_rms = '0;
    i_rms = '0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(ADDR_SCALE, 24'h4ccccc);
    for (k = 0; k < NCH; k++) begin
      rd(AW'(ADDR_GAIN + k), 24'h400000);
      rd(AW'(ADDR_DCOFF + k), 24'h0);
    end
    rd(ADDR_ACOFF, 24'h0);
    rd(AW'(ADDR_ACOFF + 1), 24'h0);
    rd(5'h1f, 24'h0);
    wr(ADDR_COUNT, 24'h4);
    wr(ADDR_SETTLE, 24'h2);
    rd(ADDR_COUNT, 24'h4);
    // dc offset on channel 0 with gain one and offset zero
    @(posedge ref_clk);
    raw_sample[0] <= r;
    raw_sample[1] <= r;
    go(4'h1);
    tick();
    rd(ADDR_DCOFF, 24'h0);
    wr(ADDR_CMD, 24'h9);
    fin();
    repeat (3) @(negedge ref_clk);
    chk("busy_after", '0, {23'h0, cal_busy});
    rd(ADDR_DCOFF, ~r + 24'h1);
    rd(AW'(ADDR_DCOFF + 2), 24'h0);
    rd(ADDR_STATUS, 24'h800000);
    tick();
    chk("sample0", 24'h0, corrected_sample[0]);
    chk("sample1", r, corrected_sample[1]);
    // ac offset on current 1 after clearing its coefficient
    wr(ADDR_ACOFF, 24'h0);
    i_rms[0] <= 24'h100000;
    go(4'h6);
    fin();
    rd(ADDR_ACOFF, 24'h010000);
    rd(AW'(ADDR_ACOFF + 1), 24'h0);
    mean_sq_in[0] <= 24'h020000;
    mean_sq_in[1] <= 24'h000005;
    tick();
    chk("ms0", 24'h010000, corrected_mean_sq[0]);
    chk("ms1", 24'h000005, corrected_mean_sq[1]);
    chk("sample1_ac", r, corrected_sample[1]);
    mean_sq_in[0] <= 24'h008000;
    tick();
    chk("ms0_floor", 24'h0, corrected_mean_sq[0]);
    // gains at one, references applied before each gain run
    wr(ADDR_SCALE, 24'h266666);
    v_rms[0] <= 24'h4ccccc;
    v_rms[1] <= 24'h100000;
    i_rms[0] <= 24'h4ccccc;
    go(4'h3);
    fin();
    rd(ADDR_GAIN, 24'h800000);
    go(4'h7);
    fin();
    rd(AW'(ADDR_GAIN + 1), 24'h400000);
    wr(ADDR_ACOFF, 24'h010000);
    go(4'hb);
    fin();
    rd(AW'(ADDR_GAIN + 2), 24'hffffff);
    rd(ADDR_STATUS, 24'h800004);
    repeat (3) @(negedge ref_clk);
    final_report();
  end
endmodule : meter_calibration_engine_test
